// file: verilog/vrcm_top.sv
// Purpose: Master volume with soft ramping and bit-clock monitor
// Assumes: Host register port on sys_clk, audio pins asynchronous
// Notes:   Gain index 0 is loudest, all ones is mute
//
// Contract
// - Ratio low byte readable, read-only
// - Valid only stable and 32 to 512
// - Bit 5 flags bit clock rate error
// - Bit 4 flags PLL overrate
// - Bit 3 lock, unlocked when PLL disabled
// - Bit 2 flags missing bit clock
// - Bit 0 rate invalid or mismatch
// - Rate error shows despite ignore setting
// - One volume code for both channels
// - Half-dB steps, 0x30 unity gain
// - All-ones volume code mutes fully
// - Down rate 1/2/4 periods or instant
// - Down step 4/2/1/0.5 dB
// - Up rate 1/2/4 periods or instant
// - Up step 4/2/1/0.5 dB
// - Emergency ramp down uses own fields
// - Ratio top two bits readable
`timescale 1ns/10ps
`include "vrcm_consts.svh"
module vrcm_top (
	input  wire logic                   sys_clk,
	input  wire logic                   reset,
	input  wire vrcm_pkg::vrcm_reg_req_s reg_req,
	output logic [7:0]                  reg_rdata,
	input  wire logic                   serial_bit_clock,
	input  wire logic                   frame_clock,
	input  wire logic                   pll_enable,
	input  wire logic                   pll_locked,
	input  wire logic                   pll_overrate,
	input  wire logic                   power_loss,
	input  wire logic [3:0]             fs_mode,
	input  wire logic [3:0]             fs_detected,
	input  wire logic                   fs_err_ignore,
	input  wire vrcm_pkg::vrcm_sample_s  sample_in,
	output vrcm_pkg::vrcm_sample_s      sample_out,
	output logic                        emergency_active
);
	import vrcm_pkg::*;

	function automatic logic [1:0] rate_mask(input logic [1:0] rate);
		case (rate)
			2'h0:    rate_mask = 2'h0;
			2'h1:    rate_mask = 2'h1;
			default: rate_mask = 2'h3;
		endcase
	endfunction

	function automatic logic [8:0] step_size(input logic [1:0] code);
		case (code)
			2'h0:    step_size = 9'h008;
			2'h1:    step_size = 9'h004;
			2'h2:    step_size = 9'h002;
			default: step_size = 9'h001;
		endcase
	endfunction

	// Pin synchronisers
	logic [5:0] pins_s;
	logic       bck_s, frm_s, pll_en_s, pll_lock_s, pll_over_s, pwr_loss_s;

	vrcm_sync2 #(.WIDTH(6)) u_sync (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.async_in ({power_loss, pll_overrate, pll_locked, pll_enable,
		            frame_clock, serial_bit_clock}),
		.sync_out (pins_s)
	);
	assign {pwr_loss_s, pll_over_s, pll_lock_s, pll_en_s, frm_s, bck_s}
		= pins_s;

	// Bit clock monitor
	logic       bck_prev, frm_prev, next_bck_prev, next_frm_prev;
	logic [9:0] bck_cnt, ratio, next_bck_cnt, next_ratio;
	logic       stable, next_stable;
	logic [8:0] miss_cnt, next_miss_cnt;
	logic [5:0] flags, next_flags;
	logic       bck_rise, frame_tick, missing, ratio_ok;

	assign bck_rise   = bck_s & ~bck_prev;
	assign frame_tick = frm_s & ~frm_prev;
	assign missing    = miss_cnt == `VRCM_MISS_CYC;
	assign ratio_ok   = ratio >= `VRCM_RATIO_MIN && ratio <= `VRCM_RATIO_MAX;

	always_comb begin
		next_bck_prev = bck_s;
		next_frm_prev = frm_s;
		next_bck_cnt  = bck_cnt;
		next_ratio    = ratio;
		next_stable   = stable;
		next_miss_cnt = miss_cnt;
		if (bck_rise)
			next_miss_cnt = '0;
		else if (!missing)
			next_miss_cnt = miss_cnt + 9'h001;
		if (frame_tick) begin
			next_ratio   = bck_cnt;
			next_stable  = bck_cnt == ratio;
			next_bck_cnt = {9'h000, bck_rise};
		end else if (bck_rise && bck_cnt != `VRCM_RATIO_SAT) begin
			next_bck_cnt = bck_cnt + 10'h001;
		end
		next_flags = '0;
		next_flags[`VRCM_ST_RATE_ERR] = !missing && !ratio_ok;
		next_flags[`VRCM_ST_PLL_OVER] = pll_over_s;
		next_flags[`VRCM_ST_PLL_LOCK] = pll_en_s && pll_lock_s;
		next_flags[`VRCM_ST_BCK_MISS] = missing;
		next_flags[`VRCM_ST_BCK_VALID] = stable && ratio_ok && !missing;
		if (fs_mode == `VRCM_FS_AUTO)
			next_flags[`VRCM_ST_FS_ERR] = fs_detected == `VRCM_FS_ERROR;
		else
			next_flags[`VRCM_ST_FS_ERR] = fs_detected != fs_mode;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			bck_prev <= 1'b0;
			frm_prev <= 1'b0;
			bck_cnt  <= '0;
			ratio    <= '0;
			stable   <= 1'b0;
			miss_cnt <= '0;
			flags    <= '0;
		end else begin
			bck_prev <= next_bck_prev;
			frm_prev <= next_frm_prev;
			bck_cnt  <= next_bck_cnt;
			ratio    <= next_ratio;
			stable   <= next_stable;
			miss_cnt <= next_miss_cnt;
			flags    <= next_flags;
		end
	end

	// Register file
	logic [7:0] volume, ramp_ctl, emerg_ctl, next_volume, next_ramp_ctl;
	logic [7:0] next_emerg_ctl, next_reg_rdata;
	logic [1:0] stat_rsv, next_stat_rsv;
	logic       wr;

	assign wr = reg_req.write;

	always_comb begin
		next_volume    = volume;
		next_ramp_ctl  = ramp_ctl;
		next_emerg_ctl = emerg_ctl;
		next_stat_rsv  = stat_rsv;
		next_reg_rdata = reg_rdata;
		if (wr) begin
			case (reg_req.addr)
				`VRCM_ADDR_VOLUME: next_volume    = reg_req.wdata;
				`VRCM_ADDR_RAMP:   next_ramp_ctl  = reg_req.wdata;
				`VRCM_ADDR_EMERG:  next_emerg_ctl = reg_req.wdata;
				`VRCM_ADDR_STATUS:
					next_stat_rsv = reg_req.wdata[`VRCM_F_STAT_RSV];
				default: ;
			endcase
		end
		if (reg_req.read) begin
			next_reg_rdata = `VRCM_RST_BYTE;
			case (reg_req.addr)
				`VRCM_ADDR_RATIO_HI:
					next_reg_rdata[`VRCM_F_RATIO_HI] = ratio[`VRCM_F_RATIO_TOP];
				`VRCM_ADDR_RATIO_LO: next_reg_rdata = ratio[`VRCM_F_RATIO_LOW];
				`VRCM_ADDR_STATUS:   next_reg_rdata = {stat_rsv, flags};
				`VRCM_ADDR_VOLUME:   next_reg_rdata = volume;
				`VRCM_ADDR_RAMP:     next_reg_rdata = ramp_ctl;
				`VRCM_ADDR_EMERG:    next_reg_rdata = emerg_ctl;
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			volume    <= `VRCM_RST_VOLUME;
			ramp_ctl  <= `VRCM_RST_RAMP;
			emerg_ctl <= `VRCM_RST_EMERG;
			stat_rsv  <= '0;
			reg_rdata <= `VRCM_RST_BYTE;
		end else begin
			volume    <= next_volume;
			ramp_ctl  <= next_ramp_ctl;
			emerg_ctl <= next_emerg_ctl;
			stat_rsv  <= next_stat_rsv;
			reg_rdata <= next_reg_rdata;
		end
	end

	// Ramp engine
	vrcm_state_e state, next_state;
	logic [7:0]  cur, next_cur, target;
	logic [1:0]  div_cnt, next_div_cnt, rate, step_code;
	logic        clock_err, tick, next_emergency;
	logic [8:0]  sum, diff;

	assign clock_err = flags[`VRCM_ST_BCK_MISS] || !flags[`VRCM_ST_BCK_VALID]
		|| (flags[`VRCM_ST_FS_ERR] && !fs_err_ignore) || pwr_loss_s;
	assign target = (state == VRCM_EMERG) ? `VRCM_VOL_MUTE : volume;

	always_comb begin
		case (state)
			VRCM_EMERG: begin
				rate      = emerg_ctl[`VRCM_F_DN_RATE];
				step_code = emerg_ctl[`VRCM_F_DN_STEP];
			end
			VRCM_UP: begin
				rate      = ramp_ctl[`VRCM_F_UP_RATE];
				step_code = ramp_ctl[`VRCM_F_UP_STEP];
			end
			default: begin
				rate      = ramp_ctl[`VRCM_F_DN_RATE];
				step_code = ramp_ctl[`VRCM_F_DN_STEP];
			end
		endcase
	end

	assign tick = frame_tick && ((div_cnt & rate_mask(rate)) == 2'h0);
	assign sum  = {1'b0, cur} + step_size(step_code);
	assign diff = {1'b0, cur} - step_size(step_code);

	always_comb begin
		next_state   = state;
		next_cur     = cur;
		next_div_cnt = frame_tick ? div_cnt + 2'h1 : div_cnt;
		case (state)
			VRCM_IDLE: begin
				next_div_cnt = '0;
				if (clock_err)
					next_state = VRCM_EMERG;
				else if (cur < target)
					next_state = VRCM_DOWN;
				else if (cur > target)
					next_state = VRCM_UP;
			end
			VRCM_DOWN, VRCM_EMERG: begin
				if (rate == `VRCM_RATE_INSTANT)
					next_cur = target;
				else if (tick)
					next_cur = (sum >= {1'b0, target}) ? target : sum[7:0];
				if (state == VRCM_DOWN && clock_err)
					next_state = VRCM_EMERG;
				else if (state == VRCM_EMERG && !clock_err)
					next_state = VRCM_IDLE;
				else if (state == VRCM_DOWN && next_cur == target)
					next_state = VRCM_IDLE;
			end
			VRCM_UP: begin
				if (rate == `VRCM_RATE_INSTANT)
					next_cur = target;
				else if (tick)
					next_cur = (diff[8] || diff[7:0] <= target)
						? target : diff[7:0];
				if (clock_err)
					next_state = VRCM_EMERG;
				else if (next_cur == target)
					next_state = VRCM_IDLE;
			end
			default: next_state = VRCM_IDLE;
		endcase
		next_emergency = next_state == VRCM_EMERG;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state            <= VRCM_IDLE;
			cur              <= `VRCM_RST_VOLUME;
			div_cnt          <= '0;
			emergency_active <= 1'b0;
		end else begin
			state            <= next_state;
			cur              <= next_cur;
			div_cnt          <= next_div_cnt;
			emergency_active <= next_emergency;
		end
	end

	vrcm_gain_apply u_gain (
		.sys_clk    (sys_clk),
		.reset      (reset),
		.gain_idx   (cur),
		.sample_in  (sample_in),
		.sample_out (sample_out)
	);

	property p_ratio_read;
		@(posedge sys_clk) disable iff (reset)
		reg_req.read && reg_req.addr == `VRCM_ADDR_RATIO_LO
		|=> reg_rdata == $past(ratio[7:0]);
	endproperty
	a_ratio_read: assert property (p_ratio_read)
		else $error("ratio low byte read wrong");

	property p_valid_range;
		@(posedge sys_clk) disable iff (reset)
		flags[`VRCM_ST_BCK_VALID] |-> $past(ratio) >= `VRCM_RATIO_MIN
		&& $past(ratio) <= `VRCM_RATIO_MAX && $past(stable);
	endproperty
	a_valid_range: assert property (p_valid_range)
		else $error("bit clock valid outside range");

	property p_rate_err;
		@(posedge sys_clk) disable iff (reset)
		flags[`VRCM_ST_RATE_ERR] |-> !flags[`VRCM_ST_BCK_VALID];
	endproperty
	a_rate_err: assert property (p_rate_err)
		else $error("rate error with valid clock");

	property p_lock_disabled;
		@(posedge sys_clk) disable iff (reset)
		!pll_en_s |=> !flags[`VRCM_ST_PLL_LOCK];
	endproperty
	a_lock_disabled: assert property (p_lock_disabled)
		else $error("lock shown while PLL disabled");

	property p_down_instant;
		@(posedge sys_clk) disable iff (reset)
		state == VRCM_DOWN && rate == `VRCM_RATE_INSTANT
		|=> cur == $past(target);
	endproperty
	a_down_instant: assert property (p_down_instant)
		else $error("instant down did not jump");

	property p_down_step;
		@(posedge sys_clk) disable iff (reset)
		state == VRCM_DOWN && rate != `VRCM_RATE_INSTANT && !tick
		|=> $stable(cur);
	endproperty
	a_down_step: assert property (p_down_step)
		else $error("gain moved between updates");

	property p_no_overshoot;
		@(posedge sys_clk) disable iff (reset)
		state == VRCM_UP |=> cur >= $past(target);
	endproperty
	a_no_overshoot: assert property (p_no_overshoot)
		else $error("ramp up overshot target");

	property p_emerg_entry;
		@(posedge sys_clk) disable iff (reset)
		$rose(pwr_loss_s) |-> ##[1:2] state == VRCM_EMERG;
	endproperty
	a_emerg_entry: assert property (p_emerg_entry)
		else $error("power loss did not start emergency ramp");
endmodule

// file: common/vrcm_consts.svh
// Purpose: Constants of the volume ramp and clock monitor block
// Assumes: 200 MHz system clock
// Notes:   Field ranges are written as msb:lsb for part selects
`ifndef VRCM_CONSTS_SVH
`define VRCM_CONSTS_SVH

`define VRCM_ADDR_RATIO_HI  8'h37
`define VRCM_ADDR_RATIO_LO  8'h38
`define VRCM_ADDR_STATUS    8'h39
`define VRCM_ADDR_VOLUME    8'h4C
`define VRCM_ADDR_RAMP      8'h4E
`define VRCM_ADDR_EMERG     8'h4F

`define VRCM_RST_VOLUME     8'h30
`define VRCM_RST_RAMP       8'h33
`define VRCM_RST_EMERG      8'h30
`define VRCM_RST_BYTE       8'h00

`define VRCM_F_DN_RATE      7:6
`define VRCM_F_DN_STEP      5:4
`define VRCM_F_UP_RATE      3:2
`define VRCM_F_UP_STEP      1:0
`define VRCM_F_STAT_RSV     7:6
`define VRCM_F_RATIO_HI     5:4
`define VRCM_F_RATIO_TOP    9:8
`define VRCM_F_RATIO_LOW    7:0

`define VRCM_ST_RATE_ERR    5
`define VRCM_ST_PLL_OVER    4
`define VRCM_ST_PLL_LOCK    3
`define VRCM_ST_BCK_MISS    2
`define VRCM_ST_BCK_VALID   1
`define VRCM_ST_FS_ERR      0

`define VRCM_RATIO_MIN      10'h020
`define VRCM_RATIO_MAX      10'h200
`define VRCM_RATIO_SAT      10'h3FF
`define VRCM_VOL_MUTE       8'hFF
`define VRCM_FS_AUTO        4'h0
`define VRCM_FS_ERROR       4'h0
`define VRCM_RATE_INSTANT   2'h3

`define VRCM_CLK_MHZ        200
`define VRCM_MISS_NS        2000
`define VRCM_MISS_CYC       9'(((`VRCM_MISS_NS) * (`VRCM_CLK_MHZ)) / 1000)

`define VRCM_MANT_FRAC      15
`define VRCM_GAIN_BOOST     4
`define VRCM_STEPS_PER_6DB  12

`endif

// file: common/vrcm_pkg.sv
// Purpose: Types shared by the volume ramp and clock monitor block
// Assumes: 24-bit stereo samples
// Notes:   Constants live in vrcm_consts.svh
package vrcm_pkg;
	typedef enum logic [3:0] {
		VRCM_IDLE  = 4'h1,
		VRCM_DOWN  = 4'h2,
		VRCM_UP    = 4'h4,
		VRCM_EMERG = 4'h8
	} vrcm_state_e;

	typedef struct packed {
		logic               valid;
		logic signed [23:0] left;
		logic signed [23:0] right;
	} vrcm_sample_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       write;
		logic       read;
	} vrcm_reg_req_s;
endpackage

// file: verilog/vrcm_sync2.sv
// Purpose: Two-flop synchroniser for a group of pin levels
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module vrcm_sync2 #(
	parameter int WIDTH = 6
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					stage1[i]   <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					stage1[i]   <= async_in[i];
					sync_out[i] <= stage1[i];
				end
			end
		end
	endgenerate
endmodule

// file: verilog/vrcm_gain_apply.sv
// Purpose: Scales both channels by a half-dB gain index
// Assumes: Index 0 is +24 dB, all ones is mute
// Notes:   One cycle latency, saturating output
`timescale 1ns/10ps
`include "vrcm_consts.svh"
module vrcm_gain_apply (
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	input  wire logic [7:0]            gain_idx,
	input  wire vrcm_pkg::vrcm_sample_s sample_in,
	output vrcm_pkg::vrcm_sample_s     sample_out
);
	import vrcm_pkg::*;

	vrcm_sample_s next_sample_out;
	logic [3:0]   frac;
	logic [4:0]   octave;

	// Mantissa of 10^(-k/40) in Q15 for each half-dB step
	function automatic logic [15:0] mantissa(input logic [3:0] k);
		case (k)
			4'h0: mantissa = 16'h8000;
			4'h1: mantissa = 16'h78D7;
			4'h2: mantissa = 16'h7215;
			4'h3: mantissa = 16'h6BB3;
			4'h4: mantissa = 16'h65AD;
			4'h5: mantissa = 16'h5FFD;
			4'h6: mantissa = 16'h5A9E;
			4'h7: mantissa = 16'h558C;
			4'h8: mantissa = 16'h50C3;
			4'h9: mantissa = 16'h4C3F;
			4'hA: mantissa = 16'h47FB;
			4'hB: mantissa = 16'h43F4;
			default: mantissa = 16'h0000;
		endcase
	endfunction

	function automatic logic signed [23:0] scale(
		input logic signed [23:0] s,
		input logic [3:0]         k,
		input logic [4:0]         oct
	);
		logic signed [40:0] prod;
		logic signed [40:0] shifted;
		prod    = 41'(s * $signed({1'b0, mantissa(k)}));
		shifted = prod >>> (`VRCM_MANT_FRAC - `VRCM_GAIN_BOOST + oct);
		if (shifted > 41'sh0007FFFFF)
			scale = 24'sh7FFFFF;
		else if (shifted < -41'sh000800000)
			scale = -24'sh800000;
		else
			scale = shifted[23:0];
	endfunction

	assign frac   = 4'(gain_idx % `VRCM_STEPS_PER_6DB);
	assign octave = 5'(gain_idx / `VRCM_STEPS_PER_6DB);

	always_comb begin
		next_sample_out.valid = sample_in.valid;
		if (gain_idx == `VRCM_VOL_MUTE) begin
			next_sample_out.left  = '0;
			next_sample_out.right = '0;
		end else begin
			next_sample_out.left  = scale(sample_in.left, frac, octave);
			next_sample_out.right = scale(sample_in.right, frac, octave);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			sample_out <= '0;
		else
			sample_out <= next_sample_out;
	end

	property p_mute_zero;
		@(posedge sys_clk) disable iff (reset)
		gain_idx == `VRCM_VOL_MUTE |=> sample_out.left == 0 && sample_out.right == 0;
	endproperty
	a_mute_zero: assert property (p_mute_zero)
		else $error("mute code did not silence output");
endmodule

// file: verification/vrcm_audio_src.sv
// Purpose: Serial audio clock source facing the block
// Assumes: Bit clock period 20 ns; frame clock moves while bit clock low
// Notes:   Both clocks stand still low while run is low
`timescale 1ns/10ps
module vrcm_audio_src (
	input  wire logic       run,
	input  wire logic [9:0] ratio,
	output logic            serial_bit_clock,
	output logic            frame_clock
);
	int i;

	initial begin
		serial_bit_clock = 1'b0;
		frame_clock = 1'b0;
		forever begin
			if (!run) begin
				serial_bit_clock = 1'b0;
				frame_clock = 1'b0;
				@(posedge run);
			end
			// One frame of ratio bit clocks, frame high first half
			for (i = 0; i < int'(ratio); i++) begin
				frame_clock = (i < int'(ratio) / 2);
				#10 serial_bit_clock = 1'b1;
				#10 serial_bit_clock = 1'b0;
			end
		end
	end
endmodule

// file: verification/vrcm_top_tb.sv
// Purpose: Self-checking bench for volume ramp and clock monitor
// Assumes: Ratio 48 gives a 192-cycle sample period
// Notes:   Levels use exact 6 dB gain points and mute only
`timescale 1ns/10ps
`include "vrcm_consts.svh"
module vrcm_top_tb;
	import vrcm_pkg::*;

	logic          sys_clk;
	logic          reset;
	vrcm_reg_req_s reg_req;
	logic [7:0]    reg_rdata;
	logic          serial_bit_clock;
	logic          frame_clock;
	logic          pll_enable;
	logic          pll_locked;
	logic          pll_overrate;
	logic          power_loss;
	logic [3:0]    fs_mode;
	logic [3:0]    fs_detected;
	logic          fs_err_ignore;
	vrcm_sample_s  sample_in;
	vrcm_sample_s  sample_out;
	logic          emergency_active;
	logic          src_run;
	logic [9:0]    src_ratio;
	logic [7:0]    rd;
	logic          ok;
	logic [39:0]   rows [18];
	int            errors;
	int            checks_done;
	int            f;

	vrcm_top uut (
		.sys_clk          (sys_clk),
		.reset            (reset),
		.reg_req          (reg_req),
		.reg_rdata        (reg_rdata),
		.serial_bit_clock (serial_bit_clock),
		.frame_clock      (frame_clock),
		.pll_enable       (pll_enable),
		.pll_locked       (pll_locked),
		.pll_overrate     (pll_overrate),
		.power_loss       (power_loss),
		.fs_mode          (fs_mode),
		.fs_detected      (fs_detected),
		.fs_err_ignore    (fs_err_ignore),
		.sample_in        (sample_in),
		.sample_out       (sample_out),
		.emergency_active (emergency_active)
	);

	vrcm_audio_src src (
		.run              (src_run),
		.ratio            (src_ratio),
		.serial_bit_clock (serial_bit_clock),
		.frame_clock      (frame_clock)
	);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [23:0] seen, input logic [23:0] exp,
		input string what);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t %s: %h not %h", $time, what, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		reg_req.addr = a;
		reg_req.wdata = d;
		reg_req.write = 1'b1;
		tick(1);
		reg_req.write = 1'b0;
		tick(1);
	endtask

	task automatic reg_rd(input logic [7:0] a);
		reg_req.addr = a;
		reg_req.read = 1'b1;
		tick(1);
		reg_req.read = 1'b0;
		rd = reg_rdata;
		tick(1);
	endtask

	// Left output for input 0x010000, 12 index steps per 6 dB
	function automatic logic [23:0] lvl_of(input logic [7:0] v);
		case (v)
			8'h00: return 24'h100000;
			8'h24: return 24'h020000;
			8'h30: return 24'h010000;
			8'h3C: return 24'h008000;
			8'h48: return 24'h004000;
			default: return 24'h000000;
		endcase
	endfunction

	// Counts sample periods until the left level is reached
	task automatic wait_lvl(input logic [23:0] lvl);
		logic pf;
		int   n;
		f = 0;
		pf = frame_clock;
		for (n = 0; n < 30000 && sample_out.left !== lvl; n++) begin
			tick(1);
			if (frame_clock && !pf)
				f++;
			pf = frame_clock;
		end
		if (n == 30000) begin
			errors++;
			$display("BAD %0t level wait timed out", $time);
			end_sim();
		end
	endtask

	// Row: ramp control, start code, target code, periods, tolerance
	task automatic run_row(input logic [39:0] r);
		reg_wr(`VRCM_ADDR_RAMP, 8'hCC);
		reg_wr(`VRCM_ADDR_VOLUME, r[31:24]);
		wait_lvl(lvl_of(r[31:24]));
		tick(400);
		reg_wr(`VRCM_ADDR_RAMP, r[39:32]);
		reg_wr(`VRCM_ADDR_VOLUME, r[23:16]);
		wait_lvl(lvl_of(r[23:16]));
		ok = f >= int'(r[15:8]) - int'(r[7:0]);
		ok = ok && f <= int'(r[15:8]) + int'(r[7:0]);
		check(ok, 1'b1, "periods");
		tick(400);
		check(sample_out.left, lvl_of(r[23:16]), "held");
		check(sample_out.right, 24'h0 - lvl_of(r[23:16]), "right");
		check(sample_out.valid, 1'b1, "valid");
	endtask

	task automatic stat(input logic [3:0] p, input logic [3:0] m,
		input logic [3:0] d, input logic [7:0] exp);
		{pll_enable, pll_locked, pll_overrate, fs_err_ignore} = p;
		fs_mode = m;
		fs_detected = d;
		tick(20);
		reg_rd(`VRCM_ADDR_STATUS);
		check(rd, exp, "status");
	endtask

	initial begin
		errors = 0;
		checks_done = 0;
		reset = 1'b1;
		reg_req = '0;
		{pll_enable, pll_locked, pll_overrate, fs_err_ignore} = 4'b1100;
		power_loss = 1'b0;
		fs_mode = 4'h0;
		fs_detected = 4'h9;
		sample_in = {1'b1, 24'h010000, 24'hFF0000};
		src_run = 1'b1;
		src_ratio = 10'd48;
		rows = '{40'hCC30000001, 40'hCC30240001, 40'hCC303C0001,
			40'hCC30FF0001, 40'h0C30480301, 40'h1C30480601,
			40'h2C30480C01, 40'h3C30481801, 40'h4C30480602,
			40'h8C30480C04, 40'hCC30480001, 40'h0C303C0201,
			40'hC048300301, 40'hC148300601, 40'hC248300C01,
			40'hC348301801, 40'hC448300602, 40'hC848300C04};
		tick(2);
		reset = 1'b0;
		reg_rd(`VRCM_ADDR_VOLUME);
		check(rd, 8'h30, "volume reset");
		reg_rd(`VRCM_ADDR_RAMP);
		check(rd, 8'h33, "ramp reset");
		reg_rd(`VRCM_ADDR_EMERG);
		check(rd, 8'h30, "emerg reset");
		reg_wr(`VRCM_ADDR_RATIO_LO, 8'hAA);
		reg_rd(`VRCM_ADDR_RATIO_LO);
		check(rd, 8'h00, "ratio write");
		reg_wr(8'h40, 8'h55);
		reg_rd(8'h40);
		check(rd, 8'h00, "unmapped");
		reg_wr(`VRCM_ADDR_EMERG, 8'hA5);
		reg_rd(`VRCM_ADDR_EMERG);
		check(rd, 8'hA5, "emerg rw");
		$display("test registers done");
		tick(1200);
		reg_rd(`VRCM_ADDR_RATIO_LO);
		check(rd, 8'h30, "ratio low");
		reg_rd(`VRCM_ADDR_RATIO_HI);
		check(rd, 8'h00, "ratio high");
		stat(4'b1100, 4'h0, 4'h9, 8'h0A);
		stat(4'b1000, 4'h0, 4'h9, 8'h02);
		stat(4'b0110, 4'h0, 4'h9, 8'h12);
		stat(4'b0110, 4'h0, 4'h0, 8'h13);
		stat(4'b0111, 4'h6, 4'h9, 8'h13);
		stat(4'b0111, 4'h9, 4'h9, 8'h12);
		reg_wr(`VRCM_ADDR_STATUS, 8'hFF);
		stat(4'b1100, 4'h0, 4'h9, 8'hCA);
		$display("test monitor done");
		for (int i = 0; i < 18; i++)
			run_row(rows[i]);
		$display("test volume done");
		reg_wr(`VRCM_ADDR_EMERG, 8'h00);
		power_loss = 1'b1;
		tick(10);
		check(emergency_active, 1'b1, "emerg on");
		wait_lvl(24'h0);
		ok = f >= 22 && f <= 28;
		check(ok, 1'b1, "emerg periods");
		power_loss = 1'b0;
		tick(10);
		check(emergency_active, 1'b0, "emerg off");
		wait_lvl(24'h010000);
		reg_wr(`VRCM_ADDR_EMERG, 8'hC0);
		power_loss = 1'b1;
		wait_lvl(24'h0);
		ok = f <= 1;
		check(ok, 1'b1, "emerg instant");
		power_loss = 1'b0;
		$display("test emergency done");
		src_ratio = 10'd600;
		tick(10000);
		reg_rd(`VRCM_ADDR_RATIO_LO);
		check(rd, 8'h58, "ratio low");
		reg_rd(`VRCM_ADDR_RATIO_HI);
		check(rd, 8'h20, "ratio high");
		stat(4'b1100, 4'h0, 4'h9, 8'hE8);
		check(emergency_active, 1'b1, "invalid clock");
		src_ratio = 10'd512;
		tick(11000);
		reg_rd(`VRCM_ADDR_RATIO_LO);
		check(rd, 8'h00, "ratio low");
		reg_rd(`VRCM_ADDR_RATIO_HI);
		check(rd, 8'h20, "ratio high");
		stat(4'b1100, 4'h0, 4'h9, 8'hCA);
		src_ratio = 10'd16;
		tick(3000);
		reg_rd(`VRCM_ADDR_RATIO_LO);
		check(rd, 8'h10, "ratio low");
		stat(4'b1100, 4'h0, 4'h9, 8'hE8);
		src_run = 1'b0;
		tick(1000);
		stat(4'b1100, 4'h0, 4'h9, 8'hCC);
		check(emergency_active, 1'b1, "missing clock");
		$display("test ratio extremes done");
		end_sim();
	end
endmodule
